// [bench/brake_host.sv]
// Host model that drives the current-off pin of the block
module brake_host (
  input wire logic mclk_i,
  input wire logic req_off_i,
  output logic current_off_input_o = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pin changes just after an edge, like a slow host output
  always_ff @(posedge mclk_i) begin
    current_off_input_o <= req_off_i;
  end
endmodule // brake_host

// [bench/excitation_brake_control_tb.sv]
// Self-checking bench for the excitation and brake block
module excitation_brake_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_i = 1'b0, rst_n_i = 1'b0, off_req = 1'b0;
  logic wr = 1'b0, wd = 1'b0, r, pin, set_o, win_o, brk_o, ign_o;
  logic [3:0] exp_q[$];
  logic [3:0] e;
  int miscompares = 0, checks_done = 0, cyc = 0;
  event take;
  always #20 mclk_i = ~mclk_i;
  brake_host host (.mclk_i(mclk_i), .req_off_i(off_req),
    .current_off_input_o(pin));
  excitation_brake_control uut (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .current_off_input_i(pin), .excite_wr_i(wr), .excite_wdata_i(wd),
    .excite_setting_o(set_o), .windings_on_o(win_o),
    .brake_control_output_o(brk_o), .wr_ignored_o(ign_o));
  ////////////////////////////////////////////////////////////////////////
  // Compare tasks and closing report
  task automatic cmp_st(input logic [2:0] g, input logic [2:0] x);
    checks_done++;
    if (g !== x) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic cmp_ign(input logic g, input logic x);
    checks_done++;
    if (g !== x) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Drivers note {ignored, setting, windings, brake}
  task automatic wr_op(input logic d, input logic [3:0] x);
    @(posedge mclk_i);
    wr <= 1'b1;
    wd <= d;
    @(posedge mclk_i);
    wr <= 1'b0;
    exp_q.push_back(x);
    #1 ->take;
  endtask
  task automatic pin_op(input logic v, input logic [3:0] x);
    @(posedge mclk_i);
    off_req <= v;
    exp_q.push_back(x);
    repeat (10) @(posedge mclk_i);
    #1 ->take;
  endtask
  // Drops current-off and writes 0 in the very cycle of the inactive edge
  task automatic edge_wr(input logic [3:0] x);
    @(posedge mclk_i);
    off_req <= 1'b0;
    repeat (5) @(posedge mclk_i);
    wr <= 1'b1;
    wd <= 1'b0;
    @(posedge mclk_i);
    wr <= 1'b0;
    exp_q.push_back(x);
    #1 ->take;
  endtask
  // Monitor takes the oldest note when a result is due
  always @(take) begin
    e = exp_q.pop_front();
    cmp_st({set_o, win_o, brk_o}, e[2:0]);
    cmp_ign(ign_o, e[3]);
    $display("test done at %0t", $time);
  end
  // Hang guard
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc > 3000) begin
      miscompares++;
      end_sim();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    void'($urandom(22145));
    repeat (10) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    // Reset state: excited, brake released
    @(posedge mclk_i);
    exp_q.push_back(4'b0110);
    #1 ->take;
    for (int i = 0; i < 6; i++) begin
      r = 1'($urandom % 2);
      wr_op(r, {1'b0, r, r, ~r});
    end
    wr_op(1'b1, 4'b0110);
    pin_op(1'b1, 4'b0001);
    wr_op(1'b1, 4'b1001);
    pin_op(1'b0, 4'b0110);
    wr_op(1'b0, 4'b0001);
    pin_op(1'b1, 4'b0001);
    wr_op(1'b1, 4'b1001);
    pin_op(1'b0, 4'b0110);
    pin_op(1'b1, 4'b0001);
    edge_wr(4'b1110);
    // Let the monitor take the last note before the report
    repeat (2) @(posedge mclk_i);
    end_sim();
  end
endmodule // excitation_brake_control_tb

// [hw/excitation_brake_control.sv]
// Winding excitation and brake control with current-off override
//
// How it works
// [R1] Current-off input overrides the software excitation setting.
// [R2] Active edge while excited clears setting, de-energizes, asserts brake.
// [R3] While current-off is active, software writes to the setting are dropped.
// [R4] Inactive-going edge sets setting, re-energizes, releases brake.
// [R5] With input inactive, software 1->0 brakes, 0->1 re-energizes.
// [R6] With setting already 0, active edge or level does nothing.
// [R7] Pin synchronised; edges found by sample compare, each acted on once.
module excitation_brake_control
  import excite_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic current_off_input_i,
  input wire logic excite_wr_i,
  input wire logic excite_wdata_i,
  output logic excite_setting_o,
  output logic windings_on_o,
  output logic brake_control_output_o,
  output logic wr_ignored_o
);
  import excite_pkg::*;

  typedef struct packed {
    logic prev;
    logic excite;
    logic brake;
    logic ignored;
  } ctl_state_t;

  ctl_state_t state_ff;
  ctl_state_t nxt_state;
  logic cur_off_lvl;
  logic act_edge;
  logic inact_edge;
  logic cur_off_on;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser
  pin_sync #(
    .RST_VAL(~CUROFF_ACTIVE)
  ) u_sync (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .pin_i(current_off_input_i),
    .level_o(cur_off_lvl)
  );

  // Edge detection against the previous filtered sample
  assign cur_off_on = (cur_off_lvl == CUROFF_ACTIVE);
  assign act_edge = cur_off_on && (state_ff.prev != CUROFF_ACTIVE); // [R7]
  assign inact_edge = !cur_off_on && (state_ff.prev == CUROFF_ACTIVE); // [R7]

  ////////////////////////////////////////////////////////////////////////////
  // Excitation decision, pin before software
  always_comb begin
    nxt_state = state_ff;
    nxt_state.prev = cur_off_lvl;
    nxt_state.ignored = 1'b0;
    if (act_edge) begin
      // Only acts when currently excited
      if (state_ff.excite) begin // [R6]
        nxt_state.excite = 1'b0; // [R2]
      end
      nxt_state.ignored = excite_wr_i; // [R1]
    end else if (inact_edge) begin
      nxt_state.excite = 1'b1; // [R4]
      nxt_state.ignored = excite_wr_i; // [R1]
    end else if (cur_off_on) begin
      nxt_state.ignored = excite_wr_i; // [R3]
    end else if (excite_wr_i) begin
      nxt_state.excite = excite_wdata_i; // [R5]
    end
    nxt_state.brake = ~nxt_state.excite; // [R2] [R4] [R5]
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= '{prev: ~CUROFF_ACTIVE, excite: EXCITE_RST,
                    brake: BRAKE_RST, ignored: 1'b0};
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign excite_setting_o = state_ff.excite;
  assign windings_on_o = state_ff.excite;
  assign brake_control_output_o = state_ff.brake;
  assign wr_ignored_o = state_ff.ignored;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  // Reset leaves the windings energized with the brake released
  AST_RST_VAL: assert property ( // [R4]
    @(posedge mclk_i)
    $rose(rst_n_i) |-> excite_setting_o && windings_on_o &&
    !brake_control_output_o && !wr_ignored_o)
    else $error("reset state not excited with brake off");

  // Brake always opposes the excitation setting
  AST_BRAKE_INV: assert property ( // [R5]
    @(posedge mclk_i) disable iff (!rst_n_i)
    brake_control_output_o == !excite_setting_o)
    else $error("brake does not oppose excitation");

  ////////////////////////////////////////////////////////////////////////////
  // Edge response checks
  // Active edge while excited drops the setting and applies the brake
  AST_EDGE_OFF: assert property ( // [R2]
    @(posedge mclk_i) disable iff (!rst_n_i)
    act_edge && state_ff.excite |=>
    !excite_setting_o && brake_control_output_o)
    else $error("active edge did not de-energize");

  // Inactive edge restores excitation and releases the brake
  AST_EDGE_ON: assert property ( // [R4]
    @(posedge mclk_i) disable iff (!rst_n_i)
    inact_edge |=> excite_setting_o && !brake_control_output_o)
    else $error("inactive edge did not re-energize");

  // A write in the inactive-edge cycle is dropped and flagged
  AST_EDGE_WR: assert property ( // [R1]
    @(posedge mclk_i) disable iff (!rst_n_i)
    inact_edge && excite_wr_i |=> wr_ignored_o && excite_setting_o)
    else $error("write in edge cycle not refused");

  // Past its active edge a held current-off keeps the windings off
  AST_OFF_HELD: assert property ( // [R1]
    @(posedge mclk_i) disable iff (!rst_n_i)
    cur_off_on && !act_edge |-> !excite_setting_o && brake_control_output_o)
    else $error("windings on while current-off held");

  // Held current-off does nothing while the setting is already 0
  AST_IDLE: assert property ( // [R6]
    @(posedge mclk_i) disable iff (!rst_n_i)
    cur_off_on && !excite_setting_o |=> !excite_setting_o)
    else $error("action taken while setting already 0");

  // Each active edge is seen for one cycle only
  AST_ONCE: assert property ( // [R7]
    @(posedge mclk_i) disable iff (!rst_n_i)
    act_edge |=> !act_edge)
    else $error("edge reported twice");

  // Each inactive edge is seen for one cycle only
  AST_INACT_ONCE: assert property ( // [R7]
    @(posedge mclk_i) disable iff (!rst_n_i)
    inact_edge |=> !inact_edge)
    else $error("inactive edge reported twice");

  ////////////////////////////////////////////////////////////////////////////
  // Software write checks
  // Writes leave the setting alone while current-off is active
  AST_WR_LOCK: assert property ( // [R3]
    @(posedge mclk_i) disable iff (!rst_n_i)
    cur_off_on && !act_edge |=> $stable(excite_setting_o))
    else $error("write changed setting while current-off active");

  // A software 1 never beats an active current-off
  AST_PRIO: assert property ( // [R1]
    @(posedge mclk_i) disable iff (!rst_n_i)
    cur_off_on && excite_wr_i && excite_wdata_i |=> !excite_setting_o ||
    $past(excite_setting_o))
    else $error("software write beat current-off");

  // With current-off inactive, outside the inactive-edge cycle, a write takes effect next cycle
  AST_SW: assert property ( // [R5]
    @(posedge mclk_i) disable iff (!rst_n_i)
    !cur_off_on && !inact_edge && excite_wr_i |=>
    excite_setting_o == $past(excite_wdata_i) &&
    brake_control_output_o == !$past(excite_wdata_i))
    else $error("software write not applied");

  // With nothing asked of it the setting keeps its value
  AST_HOLD_ON: assert property ( // [R5]
    @(posedge mclk_i) disable iff (!rst_n_i)
    !cur_off_on && !inact_edge && !excite_wr_i |=>
    $stable(excite_setting_o))
    else $error("setting changed with no request");

  // A write under current-off is flagged as ignored
  AST_IGN: assert property ( // [R3]
    @(posedge mclk_i) disable iff (!rst_n_i)
    cur_off_on && excite_wr_i |=> wr_ignored_o)
    else $error("ignored write not flagged");

  // The ignored flag only follows a write strobe
  AST_IGN_SRC: assert property ( // [R3]
    @(posedge mclk_i) disable iff (!rst_n_i)
    wr_ignored_o |-> $past(excite_wr_i))
    else $error("ignored flag without a write");

  // Writes with current-off inactive are never flagged, except in the inactive-edge cycle
  AST_NO_IGN: assert property ( // [R5]
    @(posedge mclk_i) disable iff (!rst_n_i)
    !cur_off_on && !inact_edge |=> !wr_ignored_o)
    else $error("accepted write flagged as ignored");

  // Setting only rises on an inactive edge or an accepted write of 1
  AST_RISE_CAUSE: assert property ( // [R1]
    @(posedge mclk_i) disable iff (!rst_n_i)
    $rose(excite_setting_o) |-> $past(inact_edge) ||
    ($past(excite_wr_i) && $past(excite_wdata_i) && !$past(cur_off_on)))
    else $error("setting rose without a cause");

  // Setting only falls on an active edge or an accepted write of 0
  AST_FALL_CAUSE: assert property ( // [R2]
    @(posedge mclk_i) disable iff (!rst_n_i)
    $fell(excite_setting_o) |-> $past(act_edge) ||
    ($past(excite_wr_i) && !$past(excite_wdata_i) && !$past(cur_off_on)))
    else $error("setting fell without a cause");

  ////////////////////////////////////////////////////////////////////////////
  // Pin filter checks
  // Filtered level only moves to a value the pin held for two samples
  AST_LVL_SRC: assert property ( // [R7]
    @(posedge mclk_i) disable iff (!rst_n_i)
    $changed(cur_off_lvl) |-> cur_off_lvl == $past(current_off_input_i, 3) &&
    cur_off_lvl == $past(current_off_input_i, 4))
    else $error("filtered level does not match settled pin samples");

  // Pin samples that disagree leave the filtered level where it is
  AST_LVL_HOLD: assert property ( // [R7]
    @(posedge mclk_i) disable iff (!rst_n_i)
    $past(current_off_input_i, 3) != $past(current_off_input_i, 4) |->
    $stable(cur_off_lvl))
    else $error("filtered level moved on a disagreeing sample");
endmodule // excitation_brake_control

// [hw/pin_sync.sv]
// Three-stage synchroniser with agreement filter for one pin
module pin_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic pin_i,
  output logic level_o
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } sync_state_t;

  sync_state_t state_ff;
  sync_state_t nxt_state;

  ////////////////////////////////////////////////////////////////////////////
  // Level changes only once stages two and three agree
  always_comb begin
    nxt_state = state_ff;
    nxt_state.s1 = pin_i;
    nxt_state.s2 = state_ff.s1;
    nxt_state.s3 = state_ff.s2;
    if (state_ff.s2 == state_ff.s3) begin
      nxt_state.level = state_ff.s3;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, level: RST_VAL};
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign level_o = state_ff.level;
endmodule // pin_sync

// [include/excite_pkg.sv]
// Constants shared by the excitation and brake control block
package excite_pkg;
  // Synchroniser length for the current-off pin
  localparam int SYNC_STAGES = 3;
  // Reset values
  localparam logic EXCITE_RST = 1'b1;
  localparam logic BRAKE_RST = 1'b0;
  // Active level of the current-off pin
  localparam logic CUROFF_ACTIVE = 1'b1;
endpackage : excite_pkg
